// *** hw/rcb_params.svh ***
`ifndef RCB_PARAMS_SVH
`define RCB_PARAMS_SVH

// Register offsets, bank 0
`define RCB_ADDR_CONFIG 5'h00
`define RCB_ADDR_AUTO_ACK 5'h01
`define RCB_ADDR_RX_PIPES 5'h02
`define RCB_ADDR_STATUS 5'h07

// Bank 1 byte order split and top offset
`define RCB_BANK1_REVERSED_LAST 5'h08
`define RCB_BANK1_LAST 5'h0e

// Configuration register fields
`define RCB_CFG_RX_MASK_BIT 6
`define RCB_CFG_TX_MASK_BIT 5
`define RCB_CFG_RETRY_MASK_BIT 4
`define RCB_CFG_CRC_EN_BIT 3
`define RCB_CFG_CRC_LEN_BIT 2
`define RCB_CFG_POWER_BIT 1
`define RCB_CFG_ROLE_BIT 0

// Status register fields
`define RCB_STATUS_BANK_BIT 7
`define RCB_STATUS_RX_BIT 6
`define RCB_STATUS_TX_BIT 5
`define RCB_STATUS_RETRY_BIT 4

// Reset values and writable bits
`define RCB_CONFIG_RESET 8'h08
`define RCB_AUTO_ACK_RESET 8'h3f
`define RCB_RX_PIPES_RESET 8'h03
`define RCB_CONFIG_WMASK 8'h7f
`define RCB_PIPE_WMASK 8'h3f

// Command encodings
`define RCB_CMD_READ 3'h0
`define RCB_CMD_WRITE 3'h1
`define RCB_CMD_ACTIVATE 8'h50
`define RCB_BANK_TOGGLE_KEY 8'h53

`endif

// *** hw/rcb_pkg.sv ***
package rcb_pkg;

  typedef struct packed {
    logic receive_ready_flag;
    logic transmit_done_flag;
    logic retry_limit_flag;
  } rcb_flags_t;

  typedef struct packed {
    logic receive_ready_irq_mask;
    logic transmit_done_irq_mask;
    logic retry_limit_irq_mask;
    logic checksum_enable;
    logic checksum_length_select;
    logic power_on_bit;
    logic primary_role_select;
    logic [5:0] auto_ack_pipes;
    logic [5:0] receive_enable_pipes;
  } rcb_config_t;

  typedef struct packed {
    logic [4:0] addr;
    logic [31:0] data;
  } rcb_bank1_write_t;

  typedef enum logic [2:0] {
    RCB_PH_CMD = 3'b000,
    RCB_PH_READ = 3'b001,
    RCB_PH_WRITE = 3'b010,
    RCB_PH_TOGGLE = 3'b011,
    RCB_PH_IGNORE = 3'b100
  } rcb_phase_t;

endpackage

// *** hw/rcb_sync2.sv ***
`timescale 1ns/1ps
`default_nettype none

// Two-stage level synchroniser
module rcb_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] stage1;

  if (W < 1) begin : g_bad_w
    $error("rcb_sync2: W must be at least 1");
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stage1 <= RESET_VAL;
      q <= RESET_VAL;
    end else begin
      stage1 <= d;
      q <= stage1;
    end
  end
endmodule // rcb_sync2

`default_nettype wire

// *** hw/rcb_byte_order.sv ***
`timescale 1ns/1ps
`default_nettype none

// Maps a data byte index to its byte lane
module rcb_byte_order #(
  parameter int BYTES = 4
) (
  input wire logic msb_byte_first,
  input wire logic [2:0] byte_index,
  output logic [1:0] lane,
  output logic lane_valid
);
  localparam logic [2:0] TOP = 3'(BYTES - 1);

  if (BYTES < 1 || BYTES > 4) begin : g_bad_bytes
    $error("rcb_byte_order: BYTES 1..4");
  end

  always_comb begin
    lane_valid = (byte_index <= TOP);
    if (msb_byte_first) begin
      lane = 2'(TOP - byte_index);
    end else begin
      lane = byte_index[1:0];
    end
  end
endmodule // rcb_byte_order

`default_nettype wire

// *** hw/rcb_radio_config.sv ***
// Notes on behaviour
// - Bank 0 and bank-1 9..14: LSB byte first
// - Bank-1 0..8: MSB byte first, MSB bit first
// - Activate plus 0x53 toggles bank; status bit7
// - Receive-ready flag drives interrupt unless masked
// - Transmit-done flag drives interrupt unless masked
// - Retry-limit flag drives interrupt unless masked
// - Checksum enable resets one, forced by auto-ack
// - Checksum length: zero one byte, one two
// - Power bit: one up, zero down, resets zero
// - Six auto-ack enables, all reset to one
// - Status shifts out during the command byte
`timescale 1ns/1ps
`default_nettype none
`include "rcb_params.svh"

module rcb_radio_config #(
  parameter int BANK1_BYTES = 4
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic spi_clk,
  input wire logic chip_select_n,
  input wire logic mosi,
  output logic miso_out,
  output logic miso_oe,
  input wire rcb_pkg::rcb_flags_t flags,
  output logic interrupt_n,
  output rcb_pkg::rcb_config_t config_out,
  output rcb_pkg::rcb_bank1_write_t bank1_write,
  output logic bank1_write_valid
);
  import rcb_pkg::*;

  if (BANK1_BYTES < 1 || BANK1_BYTES > 4) begin : g_bad_bytes
    $error("rcb_radio_config: BANK1_BYTES must be 1..4");
  end

  // Reset view: masks off, checksum on, six acks, pipes 0 and 1
  localparam rcb_config_t CONFIG_RESET = {3'h0, 4'h8, 6'h3f, 6'h03};

  // Serial framing state, link clock domain
  logic [2:0] bit_cnt;
  logic [6:0] rx_shift;
  logic [2:0] byte_idx;
  logic [4:0] cmd_addr;
  rcb_phase_t phase;
  logic [7:0] rx_byte;
  logic byte_done;
  logic [2:0] data_idx;
  rcb_phase_t next_phase;

  // Register storage, link clock domain
  logic [7:0] cfg_reg;
  logic [7:0] aa_reg;
  logic [7:0] rxp_reg;
  logic bank;
  logic [7:0] cfg_view;
  logic [7:0] status_byte;
  rcb_flags_t flags_spi;

  // Bank 1 word assembly
  logic [31:0] b1_word;
  logic [31:0] next_b1_word;
  logic [4:0] b1_addr;
  logic b1_toggle;
  logic [1:0] b1_lane;
  logic b1_lane_valid;
  logic b1_access;

  // Output shifter, falling edge
  logic [7:0] tx_shift;
  logic tx_live;
  logic [7:0] next_tx_byte;

  // System clock domain
  rcb_config_t config_spi;
  rcb_config_t config_sync;
  logic b1_toggle_sync;
  logic b1_toggle_seen;
  logic cfg_toggle;
  logic cfg_toggle_sync;
  logic cfg_toggle_seen;

  assign rx_byte = {rx_shift, mosi};
  assign byte_done = (bit_cnt == 3'h7);
  assign data_idx = byte_idx - 3'h1;
  assign b1_access = bank && (cmd_addr <= `RCB_BANK1_LAST);

  // Command decode of the first byte
  always_comb begin
    case (rx_byte[7:5])
      `RCB_CMD_READ: next_phase = RCB_PH_READ;
      `RCB_CMD_WRITE: next_phase = RCB_PH_WRITE;
      default: begin
        if (rx_byte == `RCB_CMD_ACTIVATE) begin
          next_phase = RCB_PH_TOGGLE;
        end else begin
          next_phase = RCB_PH_IGNORE;
        end
      end
    endcase
  end

  // Bit and byte counting, cleared by deselect
  always_ff @(posedge spi_clk or posedge reset or posedge chip_select_n) begin
    if (reset || chip_select_n) begin
      bit_cnt <= 3'h0;
      rx_shift <= 7'h00;
      byte_idx <= 3'h0;
      cmd_addr <= 5'h00;
      phase <= RCB_PH_CMD;
    end else begin
      bit_cnt <= bit_cnt + 3'h1;
      rx_shift <= rx_byte[6:0];
      if (byte_done && byte_idx != 3'h7) begin
        byte_idx <= byte_idx + 3'h1;
      end
      if (byte_done) begin
        case (phase)
          RCB_PH_CMD: begin
            phase <= next_phase;
            cmd_addr <= rx_byte[4:0];
          end
          RCB_PH_TOGGLE: phase <= RCB_PH_IGNORE;
          RCB_PH_READ: phase <= RCB_PH_READ;
          RCB_PH_WRITE: phase <= RCB_PH_WRITE;
          default: phase <= RCB_PH_IGNORE;
        endcase
      end
    end
  end

  // Bank 0 registers and bank select
  always_ff @(posedge spi_clk or posedge reset) begin
    if (reset) begin
      cfg_reg <= `RCB_CONFIG_RESET;
      aa_reg <= `RCB_AUTO_ACK_RESET;
      rxp_reg <= `RCB_RX_PIPES_RESET;
      bank <= 1'b0;
      cfg_toggle <= 1'b0;
    end else if (byte_done && !chip_select_n) begin
      if (phase == RCB_PH_WRITE && !bank && byte_idx == 3'h1) begin
        // Single-byte registers take the first data byte
        case (cmd_addr)
          `RCB_ADDR_CONFIG: cfg_reg <= rx_byte & `RCB_CONFIG_WMASK;
          `RCB_ADDR_AUTO_ACK: aa_reg <= rx_byte & `RCB_PIPE_WMASK;
          `RCB_ADDR_RX_PIPES: rxp_reg <= rx_byte & `RCB_PIPE_WMASK;
          default: cfg_reg <= cfg_reg;
        endcase
        cfg_toggle <= ~cfg_toggle;
      end
      if (phase == RCB_PH_TOGGLE && rx_byte == `RCB_BANK_TOGGLE_KEY) begin
        bank <= ~bank;
      end
    end
  end

  // Checksum enable forced while any auto-ack pipe is on
  always_comb begin
    cfg_view = cfg_reg;
    cfg_view[`RCB_CFG_CRC_EN_BIT] = cfg_reg[`RCB_CFG_CRC_EN_BIT] |
                                    (|aa_reg[5:0]);
  end

  always_comb begin
    status_byte = 8'h00;
    status_byte[`RCB_STATUS_BANK_BIT] = bank;
    status_byte[`RCB_STATUS_RX_BIT] = flags_spi.receive_ready_flag;
    status_byte[`RCB_STATUS_TX_BIT] = flags_spi.transmit_done_flag;
    status_byte[`RCB_STATUS_RETRY_BIT] = flags_spi.retry_limit_flag;
  end

  // Byte lane selection for wide bank 1 registers
  rcb_byte_order #(
    .BYTES(BANK1_BYTES)
  ) u_byte_order (
    .msb_byte_first(cmd_addr <= `RCB_BANK1_REVERSED_LAST),
    .byte_index(data_idx),
    .lane(b1_lane),
    .lane_valid(b1_lane_valid)
  );

  always_comb begin
    next_b1_word = (data_idx == 3'h0) ? 32'h0000_0000 : b1_word;
    if (b1_lane_valid) begin
      next_b1_word[{b1_lane, 3'b000} +: 8] = rx_byte;
    end
  end

  // Bank 1 writes are handed to the core after each of the first BANK1_BYTES data bytes, with the word assembled so far
  always_ff @(posedge spi_clk or posedge reset) begin
    if (reset) begin
      b1_word <= 32'h0000_0000;
      b1_addr <= 5'h00;
      b1_toggle <= 1'b0;
    end else if (byte_done && !chip_select_n && phase == RCB_PH_WRITE &&
                 b1_access && b1_lane_valid) begin
      b1_word <= next_b1_word;
      b1_addr <= cmd_addr;
      b1_toggle <= ~b1_toggle;
    end
  end

  // Read data for the next byte out, LSB byte first
  always_comb begin
    next_tx_byte = 8'h00;
    if (phase == RCB_PH_READ && !bank && data_idx == 3'h0) begin
      case (cmd_addr)
        `RCB_ADDR_CONFIG: next_tx_byte = cfg_view;
        `RCB_ADDR_AUTO_ACK: next_tx_byte = aa_reg;
        `RCB_ADDR_RX_PIPES: next_tx_byte = rxp_reg;
        `RCB_ADDR_STATUS: next_tx_byte = status_byte;
        default: next_tx_byte = 8'h00;
      endcase
    end
  end

  // Output shifter changes on the falling edge
  always_ff @(negedge spi_clk or posedge reset or posedge chip_select_n) begin
    if (reset || chip_select_n) begin
      tx_shift <= 8'h00;
      tx_live <= 1'b0;
    end else begin
      tx_live <= 1'b1;
      if (bit_cnt == 3'h0) begin
        tx_shift <= next_tx_byte;
      end else if (byte_idx == 3'h0 && bit_cnt == 3'h1) begin
        tx_shift <= {status_byte[6:0], 1'b0};
      end else begin
        tx_shift <= {tx_shift[6:0], 1'b0};
      end
    end
  end

  // First status bit is shown as soon as select falls
  assign miso_out = tx_live ? tx_shift[7] : status_byte[7];
  assign miso_oe = ~chip_select_n;

  // Flags into the link domain
  rcb_sync2 #(
    .W(3),
    .RESET_VAL(3'h0)
  ) u_flags_sync (
    .clk(spi_clk),
    .reset(reset),
    .d(flags),
    .q(flags_spi)
  );

  // Configuration into the system domain
  always_comb begin
    config_spi.receive_ready_irq_mask = cfg_reg[`RCB_CFG_RX_MASK_BIT];
    config_spi.transmit_done_irq_mask = cfg_reg[`RCB_CFG_TX_MASK_BIT];
    config_spi.retry_limit_irq_mask = cfg_reg[`RCB_CFG_RETRY_MASK_BIT];
    config_spi.checksum_enable = cfg_view[`RCB_CFG_CRC_EN_BIT];
    config_spi.checksum_length_select = cfg_reg[`RCB_CFG_CRC_LEN_BIT];
    config_spi.power_on_bit = cfg_reg[`RCB_CFG_POWER_BIT];
    config_spi.primary_role_select = cfg_reg[`RCB_CFG_ROLE_BIT];
    config_spi.auto_ack_pipes = aa_reg[5:0];
    config_spi.receive_enable_pipes = rxp_reg[5:0];
  end

  // Only a one-bit toggle crosses; the word is stable when taken
  rcb_sync2 #(
    .W(1),
    .RESET_VAL(1'b0)
  ) u_config_sync (
    .clk(sys_clk),
    .reset(reset),
    .d(cfg_toggle),
    .q(cfg_toggle_sync)
  );

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cfg_toggle_seen <= 1'b0;
      config_sync <= CONFIG_RESET;
    end else begin
      cfg_toggle_seen <= cfg_toggle_sync;
      if (cfg_toggle_sync ^ cfg_toggle_seen) begin
        config_sync <= config_spi;
      end
    end
  end

  assign config_out = config_sync;

  rcb_sync2 #(
    .W(1),
    .RESET_VAL(1'b0)
  ) u_b1_sync (
    .clk(sys_clk),
    .reset(reset),
    .d(b1_toggle),
    .q(b1_toggle_sync)
  );

  // Bank 1 word capture on toggle change
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      b1_toggle_seen <= 1'b0;
      bank1_write <= '0;
      bank1_write_valid <= 1'b0;
    end else begin
      b1_toggle_seen <= b1_toggle_sync;
      bank1_write_valid <= b1_toggle_sync ^ b1_toggle_seen;
      if (b1_toggle_sync ^ b1_toggle_seen) begin
        bank1_write.addr <= b1_addr;
        bank1_write.data <= b1_word;
      end
    end
  end

  // Active-low interrupt from unmasked flags
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      interrupt_n <= 1'b1;
    end else begin
      interrupt_n <= ~(
        (flags.receive_ready_flag &
         ~config_sync.receive_ready_irq_mask) |
        (flags.transmit_done_flag &
         ~config_sync.transmit_done_irq_mask) |
        (flags.retry_limit_flag &
         ~config_sync.retry_limit_irq_mask));
    end
  end
endmodule // rcb_radio_config

`default_nettype wire

// *** test/rcb_radio_config_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module rcb_radio_config_sva #(
  parameter int BANK1_BYTES = 4
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic spi_clk,
  input wire logic chip_select_n,
  input wire logic mosi,
  input wire logic miso_out,
  input wire logic miso_oe,
  input wire rcb_pkg::rcb_flags_t flags,
  input wire logic interrupt_n,
  input wire rcb_pkg::rcb_config_t config_out,
  input wire rcb_pkg::rcb_bank1_write_t bank1_write,
  input wire logic bank1_write_valid
);
  import rcb_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  oe_select_a: assert property (miso_oe == !chip_select_n)
    else $error("miso enable differs from select");
  irq_level_a: assert property (
    chip_select_n [*6] ##0 (!$past(reset) && !$past(reset, 2)) |->
      interrupt_n == !(|($past(flags) & ~config_out[18:16])))
    else $error("interrupt level wrong");
  irq_masked_a: assert property (
    (config_out[18:16] == 3'h7) [*5] |-> interrupt_n)
    else $error("masked flags reach interrupt");
  reset_values_a: assert property ($fell(reset) |->
    config_out == 19'h08fc3 && interrupt_n && !bank1_write_valid)
    else $error("reset values wrong");
  crc_forced_a: assert property (
    |config_out.auto_ack_pipes |-> config_out.checksum_enable)
    else $error("checksum enable not forced");
  valid_pulse_a: assert property (
    bank1_write_valid |=> !bank1_write_valid)
    else $error("bank1 valid longer than one cycle");
  word_update_a: assert property ($changed(bank1_write) |->
    bank1_write_valid || $past(bank1_write_valid))
    else $error("bank1 word changed without valid");
  config_quiet_a: assert property (
    chip_select_n [*6] |-> $stable(config_out))
    else $error("config changed outside a frame");
endmodule // rcb_radio_config_sva

bind rcb_radio_config rcb_radio_config_sva #(.BANK1_BYTES(BANK1_BYTES)) u_sva (
  .sys_clk(sys_clk), .reset(reset), .spi_clk(spi_clk),
  .chip_select_n(chip_select_n), .mosi(mosi), .miso_out(miso_out),
  .miso_oe(miso_oe), .flags(flags), .interrupt_n(interrupt_n),
  .config_out(config_out), .bank1_write(bank1_write),
  .bank1_write_valid(bank1_write_valid));
`default_nettype wire

// *** test/rcb_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module rcb_host_model (
  output logic spi_clk,
  output logic chip_select_n,
  output logic mosi,
  input wire logic miso_out,
  input wire logic miso_oe
);
  initial begin
    spi_clk = 1'b0;
    chip_select_n = 1'b1;
    mosi = 1'b1;
  end
  // Command byte, then n data bytes taken from wr, low byte first
  task automatic xfer(input logic [7:0] cmd, input int n,
    input logic [31:0] wr, output logic [7:0] st, output logic [31:0] rd);
    logic [39:0] sh;
    logic [7:0] r [5];
    r = '{default: 8'h00};
    sh = {wr, cmd};
    chip_select_n = 1'b0;
    #24;
    for (int k = 0; k <= n; k++) begin
      for (int i = 7; i >= 0; i--) begin
        mosi = sh[i];
        #24 spi_clk = 1'b1;
        r[k][i] = miso_out;
        #24 spi_clk = 1'b0;
      end
      sh = sh >> 8;
    end
    #24 chip_select_n = 1'b1;
    mosi = ~mosi;
    #60;
    st = r[0];
    rd = {r[4], r[3], r[2], r[1]};
  endtask
endmodule // rcb_host_model
`default_nettype wire

// *** test/rcb_radio_config_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rcb_params.svh"
module rcb_radio_config_tb;
  import rcb_pkg::*;
  logic sys_clk, reset, spi_clk, chip_select_n, mosi, miso_out, miso_oe;
  logic interrupt_n, bank1_write_valid;
  rcb_flags_t flags;
  rcb_config_t config_out;
  rcb_bank1_write_t bank1_write;
  int mismatches = 0;
  int total_checks = 0;
  logic [7:0] st;
  logic [31:0] rd;
  rcb_radio_config #(.BANK1_BYTES(4)) u_dut (
    .sys_clk(sys_clk), .reset(reset), .spi_clk(spi_clk),
    .chip_select_n(chip_select_n), .mosi(mosi), .miso_out(miso_out),
    .miso_oe(miso_oe), .flags(flags), .interrupt_n(interrupt_n),
    .config_out(config_out), .bank1_write(bank1_write),
    .bank1_write_valid(bank1_write_valid));
  rcb_host_model u_host (.spi_clk(spi_clk), .chip_select_n(chip_select_n),
    .mosi(mosi), .miso_out(miso_out), .miso_oe(miso_oe));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    u_host.xfer({`RCB_CMD_WRITE, a}, 1, {24'h0, d}, st, rd);
    repeat (5) @(negedge sys_clk);
  endtask
  task automatic rdreg(input logic [4:0] a, input logic [7:0] exp);
    u_host.xfer({`RCB_CMD_READ, a}, 1, 32'h0, st, rd);
    chk(rd[7:0], exp);
  endtask
  task automatic nop_bank(input logic exp);
    u_host.xfer(8'hff, 0, 32'h0, st, rd);
    chk(st[7], exp);
  endtask
  task automatic t_reset;
    rdreg(`RCB_ADDR_CONFIG, 8'h08);
    chk(st[7], 1'b0);
    rdreg(`RCB_ADDR_AUTO_ACK, 8'h3f);
    rdreg(`RCB_ADDR_RX_PIPES, 8'h03);
    chk(interrupt_n, 1'b1);
  endtask
  task automatic t_fields;
    wr(`RCB_ADDR_CONFIG, 8'h07);
    rdreg(`RCB_ADDR_CONFIG, 8'h0f);
    chk({config_out.checksum_length_select, config_out.power_on_bit,
      config_out.primary_role_select}, 3'h7);
    wr(`RCB_ADDR_AUTO_ACK, 8'h00);
    wr(`RCB_ADDR_CONFIG, 8'h70);
    rdreg(`RCB_ADDR_CONFIG, 8'h70);
    chk(config_out.checksum_enable, 1'b0);
    wr(`RCB_ADDR_AUTO_ACK, 8'h20);
    rdreg(`RCB_ADDR_AUTO_ACK, 8'h20);
    rdreg(`RCB_ADDR_CONFIG, 8'h78);
    wr(`RCB_ADDR_RX_PIPES, 8'h3c);
    rdreg(`RCB_ADDR_RX_PIPES, 8'h3c);
    chk(config_out.receive_enable_pipes, 6'h3c);
  endtask
  task automatic t_irq;
    logic [2:0] m;
    @(negedge sys_clk);
    flags <= 3'h7;
    repeat (6) @(negedge sys_clk);
    chk(interrupt_n, 1'b1);
    for (int i = 0; i < 3; i++) begin
      m = 3'h1 << i;
      wr(`RCB_ADDR_CONFIG, {1'b0, ~m, 4'h0});
      flags <= m;
      repeat (3) @(negedge sys_clk);
      chk(interrupt_n, 1'b0);
      flags <= ~m;
      repeat (3) @(negedge sys_clk);
      chk(interrupt_n, 1'b1);
    end
    flags <= 3'h5;
    repeat (3) @(negedge sys_clk);
    nop_bank(1'b0);
    nop_bank(1'b0);
    chk(st, 8'h50);
    rdreg(`RCB_ADDR_STATUS, 8'h50);
    @(negedge sys_clk);
    flags <= 3'h0;
  endtask
  task automatic t_bank;
    u_host.xfer(`RCB_CMD_ACTIVATE, 1, 32'h73, st, rd);
    nop_bank(1'b0);
    u_host.xfer(`RCB_CMD_ACTIVATE, 1, 32'h53, st, rd);
    nop_bank(1'b1);
    u_host.xfer({`RCB_CMD_WRITE, 5'h08}, 4, 32'h44332211, st, rd);
    repeat (6) @(negedge sys_clk);
    chk(bank1_write, {5'h08, 32'h11223344});
    u_host.xfer({`RCB_CMD_WRITE, 5'h09}, 4, 32'h44332211, st, rd);
    repeat (6) @(negedge sys_clk);
    chk(bank1_write, {5'h09, 32'h44332211});
    u_host.xfer(`RCB_CMD_ACTIVATE, 1, 32'h53, st, rd);
    nop_bank(1'b0);
  endtask
  task automatic t_midreset;
    u_host.xfer(`RCB_CMD_ACTIVATE, 1, 32'h53, st, rd);
    nop_bank(1'b1);
    @(negedge sys_clk);
    reset = 1'b1;
    repeat (8) @(negedge sys_clk);
    reset = 1'b0;
    @(negedge sys_clk);
    chk(config_out, 19'h08fc3);
    chk(bank1_write, 37'h0);
    nop_bank(1'b0);
    t_reset();
  endtask
  task automatic tally_and_finish;
    if (mismatches == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    reset = 1'b1;
    flags = 3'h0;
    repeat (8) @(negedge sys_clk);
    reset = 1'b0;
    @(negedge sys_clk);
    t_reset();
    t_fields();
    t_irq();
    t_bank();
    t_midreset();
    tally_and_finish();
  end
  initial begin
    #1000000;
    mismatches++;
    tally_and_finish();
  end
endmodule // rcb_radio_config_tb
`default_nettype wire
